//--- pkg/scc_pkg.sv
// Constants and types for the successive-approximation conversion control.
// Assumes a single core clock domain; all users import the whole package.
package scc_pkg;
   localparam int          RESULT_W       = 8;
   localparam int          START_DELAY_W  = 3;
   localparam int          CONV_DIV       = 25;
   localparam int          CONV_DIV_W     = 5;
   localparam logic [7:0]  RESULT_RESET   = 8'h00;
   localparam logic [7:0]  APPROX_INIT    = 8'h80;
   localparam logic [2:0]  START_DLY_MAX  = 3'h7;
   typedef enum logic [1:0] {
      SCC_IDLE,
      SCC_HOLD,
      SCC_WAIT,
      SCC_RUN
   } scc_state_type;
endpackage

//--- hw/scc_sync.sv
// Two flip-flop synchroniser for a bus of pin inputs.
// Assumes inputs are asynchronous to core_clk; reset value is a parameter.
`timescale 1ns/1ps
`default_nettype none
module scc_sync #(
   parameter int         W        = 1,
   parameter logic [0:0] RST_VAL  = 1'b1
) (
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // Data
   input  wire logic [W-1:0]  async_in,
   output logic [W-1:0]       sync_out
);
   logic [W-1:0] meta;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta     <= {W{RST_VAL}};
         sync_out <= {W{RST_VAL}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

//--- hw/scc_core.sv
// Conversion control: strobes, bit search, result latch, done flag, data drive.
// Assumes strobes and comparator are asynchronous pins; data pins resolved outside.
// Function
// - All three strobes are active low
// - Start pulse only counts with chip select low
// - Falling strobe edge initialises search, raises done
// - Both strobes low holds block in reset
// - Conversion starts on the eighth period end after release
// - Bit-by-bit successive approximation search
// - Comparator sampled at end of each period
// - Result latched only after all bits decided
// - Completion drives done flag low
// - Read clears done and enables outputs
// - New start aborts running conversion
// - Aborted conversion leaves result latch unchanged
// - Output enable tied low with chip select low shows latest result
`timescale 1ns/1ps
`default_nettype none
module scc_core
   import scc_pkg::*;
#(
   parameter int RW  = RESULT_W,
   parameter int DIV = CONV_DIV
) (
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // Control strobes
   input  wire logic          chip_sel_n,
   input  wire logic          start_n,
   input  wire logic          out_en_n,
   // Comparator decision, high when input is at or above trial
   input  wire logic          cmp_high,
   // Status and data pins
   output logic               done_flag_n,
   output logic [RW-1:0]      data_out,
   output logic [RW-1:0]      data_oe,
   // Trial code to the ladder
   output logic [RW-1:0]      approx_register
);
   logic                   cs_s, st_s, oe_s, cmp_s;
   logic                   cs_d, st_d;
   logic                   hold;
   logic                   fall;
   logic [CONV_DIV_W-1:0]  div_cnt;
   logic                   period_end;
   logic [START_DELAY_W-1:0] dly_cnt;
   logic [RW-1:0]          bit_mask;
   logic [RW-1:0]          result;
   scc_state_type          state;
   logic                   search_done;

   // Keep or drop the trial bit on the comparator decision
   function automatic logic [RW-1:0] settle_bit(input logic [RW-1:0] code,
                                                input logic [RW-1:0] mask,
                                                input logic          keep);
      if (keep) begin
         return code;
      end else begin
         return code & ~mask;
      end
   endfunction

   // Only the second stage of each pin is read
   scc_sync #(.W(4), .RST_VAL(1'b1)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in ({chip_sel_n, start_n, out_en_n, cmp_high}),
      .sync_out ({cs_s, st_s, oe_s, cmp_s})
   );

   // Strobes low-active; hold while both low
   assign hold = !cs_s && !st_s;
   // Either strobe falling while other low enters reset
   assign fall = ((cs_d && !cs_s) || (st_d && !st_s)) && hold;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_d <= 1'b1;
         st_d <= 1'b1;
      end else begin
         cs_d <= cs_s;
         st_d <= st_s;
      end
   end

   // Conversion clock period derived from core clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= '0;
      end else if (div_cnt == CONV_DIV_W'(DIV - 1)) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end
   assign period_end = (div_cnt == CONV_DIV_W'(DIV - 1));
   // Last bit decided in an uninterrupted search
   assign search_done = !hold && state == SCC_RUN && period_end && bit_mask[0];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state           <= SCC_IDLE;
         dly_cnt         <= '0;
         bit_mask        <= '0;
         approx_register <= APPROX_INIT;
      end else if (hold) begin
         state           <= SCC_HOLD;
         dly_cnt         <= '0;
         bit_mask        <= APPROX_INIT;
         approx_register <= APPROX_INIT;
      end else begin
         unique case (state)
            SCC_IDLE: begin
            end
            SCC_HOLD: begin
               // Released: start delay counting begins
               state <= SCC_WAIT;
            end
            SCC_WAIT: begin
               if (period_end) begin
                  dly_cnt <= dly_cnt + 1'b1;
                  // Start on the eighth period end
                  if (dly_cnt == START_DLY_MAX) begin
                     state <= SCC_RUN;
                  end
               end
            end
            SCC_RUN: begin
               // Decide one bit per period at its end
               if (period_end) begin
                  approx_register <= settle_bit(approx_register, bit_mask, cmp_s) | (bit_mask >> 1);
                  bit_mask <= bit_mask >> 1;
                  if (bit_mask[0]) begin
                     state <= SCC_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Latch only on a finished search; abort leaves it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         result <= RESULT_RESET;
      end else if (search_done) begin
         result <= settle_bit(approx_register, bit_mask, cmp_s);
      end
   end

   // Done flag: completion lowers it, read or new start raises it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_flag_n <= 1'b1;
      end else if (search_done) begin
         done_flag_n <= 1'b0;
      end else if (hold || (!cs_s && !oe_s)) begin
         done_flag_n <= 1'b1;
      end
   end

   // Data drive only while selected and enabled
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= RESULT_RESET;
         data_oe  <= '0;
      end else begin
         data_out <= result;
         data_oe  <= {RW{!cs_s && !oe_s}};
      end
   end


   chk_hold_resets: assert property (@(posedge core_clk) disable iff (!rst_n)
      hold |=> (state == SCC_HOLD && approx_register == APPROX_INIT))
      else $error("hold did not reset search");
   chk_hold_done_high: assert property (@(posedge core_clk) disable iff (!rst_n)
      hold |=> done_flag_n)
      else $error("done low during hold");
   chk_data_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cs_s || oe_s) |=> (data_oe == '0))
      else $error("data driven while deselected");
   chk_read_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!cs_s && !oe_s) |=> (data_oe == {RW{1'b1}}))
      else $error("read did not enable data");
   chk_done_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(done_flag_n) |-> $past(state) == SCC_RUN && $past(bit_mask[0]))
      else $error("done fell without completion");
   chk_result_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state != SCC_RUN) |=> $stable(result))
      else $error("result changed outside search");
   chk_start_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == SCC_WAIT && $past(state) == SCC_HOLD) |-> ##[1:200] state != SCC_WAIT || hold)
      else $error("start delay too long");
   chk_sample_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == SCC_RUN && !hold && !period_end) |=> $stable(approx_register))
      else $error("trial code moved mid period");
   // Strobe edges, refused starts and the done flag
   chk_fall_init: assert property (@(posedge core_clk) disable iff (!rst_n)
      fall |=> (approx_register == APPROX_INIT && done_flag_n))
      else $error("strobe edge did not initialise search");
   chk_refused_start: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cs_s && state != SCC_HOLD) |=> (state != SCC_HOLD))
      else $error("start accepted without chip select");
   chk_done_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      search_done |=> !done_flag_n)
      else $error("done not lowered at completion");
   chk_done_stands: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!done_flag_n && !hold && (cs_s || oe_s)) |=> !done_flag_n)
      else $error("done rose without read or start");

   // Main scenarios
   cov_complete: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(done_flag_n));
   cov_read: cover property (@(posedge core_clk) disable iff (!rst_n) !done_flag_n ##1 (!cs_s && !oe_s));
   cov_abort: cover property (@(posedge core_clk) disable iff (!rst_n) state == SCC_RUN ##1 hold);
   cov_refused: cover property (@(posedge core_clk) disable iff (!rst_n) cs_s && !st_s);
   cov_start_run: cover property (@(posedge core_clk) disable iff (!rst_n) state == SCC_WAIT ##1 state == SCC_RUN);
endmodule
`default_nettype wire

//--- bench/scc_analog_model.sv
// Behavioural comparator standing in for the analog front end.
// Assumes the trial code is stable for a whole conversion period.
`timescale 1ns/1ps
`default_nettype none
module scc_analog_model (
   // Trial code and input level
   input  wire logic [7:0] approx_register,
   input  wire logic [7:0] level,
   // Decision, high when input is at or above trial
   output logic            cmp_high
);
   assign cmp_high = (approx_register <= level);
endmodule
`default_nettype wire

//--- bench/sar_conversion_control_tb.sv
// Self-checking bench for the conversion control block.
// Assumes a 50 MHz core clock and a shortened conversion period.
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_control_tb;
   import scc_pkg::*;
   localparam int DV = 4;
   logic       core_clk   = 1'b0;
   logic       rst_n      = 1'b0;
   logic       chip_sel_n = 1'b1;
   logic       start_n    = 1'b1;
   logic       out_en_n   = 1'b1;
   logic [7:0] level      = 8'h00;
   logic [7:0] last;
   logic [7:0] v;
   wire logic  cmp_high;
   wire logic  done_flag_n;
   wire logic [7:0] data_out;
   wire logic [7:0] data_oe;
   wire logic [7:0] approx_register;
   int         errors     = 0;
   int         compares   = 0;
   int         seed       = 55;
   int         n;
   int         fr;
   logic       prev_done;
   always #10 core_clk = ~core_clk;
   scc_core #(.DIV(DV)) DUT (.core_clk(core_clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n), .start_n(start_n),
      .out_en_n(out_en_n), .cmp_high(cmp_high), .done_flag_n(done_flag_n), .data_out(data_out),
      .data_oe(data_oe), .approx_register(approx_register));
   scc_analog_model u_model (.approx_register(approx_register), .level(level), .cmp_high(cmp_high));
   task automatic stop_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check1(input string what, input logic exp, input logic got);
      check8(what, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic ticks(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   function automatic logic [7:0] exp_code(input logic [7:0] lv);
      logic [7:0] c;
      c = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         if ((c | (8'h01 << b)) <= lv)
            c = c | (8'h01 << b);
      end
      return c;
   endfunction
   // Hold both strobes low, then release start
   task automatic hold_start(input logic [7:0] lv);
      level <= lv;
      chip_sel_n <= 1'b0;
      start_n <= 1'b0;
      ticks(3 * DV);
      check1("done_in_hold", 1'b1, done_flag_n);
      check8("approx_in_hold", APPROX_INIT, approx_register);
      start_n <= 1'b1;
   endtask
   task automatic wait_done(output int cnt);
      for (cnt = 0; cnt < 400 && done_flag_n !== 1'b0; cnt++)
         @(posedge core_clk);
      if (done_flag_n !== 1'b0) begin
         errors++;
         $display("mismatch done_wait expected 0 seen %b", done_flag_n);
         stop_test();
      end
   endtask
   task automatic read_check(input logic [7:0] exp);
      out_en_n <= 1'b0;
      ticks(6);
      check8("data_oe_read", 8'hff, data_oe);
      check8("data_out", exp, data_out);
      check1("done_cleared", 1'b1, done_flag_n);
      out_en_n <= 1'b1;
      ticks(6);
      check8("data_oe_idle", 8'h00, data_oe);
   endtask
   task automatic convert(input logic [7:0] lv);
      hold_start(lv);
      wait_done(n);
      check1("conv_time", 1'b1, n >= 9 * DV && n <= 16 * DV + 8);
      ticks(1);
      check8("latch_at_done", exp_code(lv), data_out);
      read_check(exp_code(lv));
      last = exp_code(lv);
   endtask
   initial begin
      ticks(4);
      rst_n <= 1'b1;
      ticks(3);
      check8("data_oe_reset", 8'h00, data_oe);
      start_n <= 1'b0;
      ticks(10);
      start_n <= 1'b1;
      ticks(20 * DV);
      check1("done_refused", 1'b1, done_flag_n);
      for (int k = 0; k < 10; k++) begin
         v = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : (k == 2) ? 8'h80 : 8'($random(seed));
         convert(v);
      end
      hold_start(8'h3c);
      ticks(12 * DV);
      hold_start(8'hc3);
      check8("latch_kept", last, data_out);
      wait_done(n);
      read_check(exp_code(8'hc3));
      // Free running: done flag drives the start strobe
      hold_start(8'h5a);
      prev_done = 1'b1;
      fr = 0;
      for (int t = 0; t < 800 && fr < 3; t++) begin
         @(posedge core_clk);
         start_n <= done_flag_n;
         if (prev_done === 1'b1 && done_flag_n === 1'b0)
            fr++;
         prev_done = done_flag_n;
      end
      ticks(2);
      check1("free_run_count", 1'b1, fr == 3);
      check8("free_run_data", exp_code(8'h5a), data_out);
      stop_test();
   end
endmodule
`default_nettype wire
